/* File: verilog/rips_defines.vh */
`ifndef RIPS_DEFINES_VH
`define RIPS_DEFINES_VH
// Register offsets (word address on the plain port)
`define RIPS_ADDR_CTRL 4'h0
`define RIPS_ADDR_EVENT 4'h1
`define RIPS_ADDR_STATUS 4'h2
// Control register field positions
`define RIPS_CTRL_PSC_LO 0
`define RIPS_CTRL_PSC_HI 1
`define RIPS_CTRL_HWFC 2
`define RIPS_CTRL_SMS_EN 3
`define RIPS_CTRL_EVR_EN 4
// Event register bits (write one to fire)
`define RIPS_EV_CALL_START 0
`define RIPS_EV_CALL_ANSWER 1
`define RIPS_EV_SMS 2
`define RIPS_EV_URC 3
`define RIPS_EV_DATA 4
`define RIPS_EV_WAKE 5
// Reset values
`define RIPS_CTRL_RESET 8'h04
// Power save configuration codes
`define RIPS_PSC_OFF 2'h0
`define RIPS_PSC_CYCLIC 2'h1
`define RIPS_PSC_RTS 2'h2
`define RIPS_PSC_DTR 2'h3
// Timing in milliseconds
`define RIPS_RI_ON_MS 1000
`define RIPS_RI_OFF_MS 4000
`define RIPS_WAKE_MS 20
`define RIPS_SLEEP_MS 2500
`endif

/* File: verilog/rips_ring_psave.v */
`timescale 1ns/1ps
`default_nettype none
`include "rips_defines.vh"
module rips_ring_psave #(
   parameter CLK_HZ = 20000000, // System clock rate
   parameter TICKS_PER_S = CLK_HZ // Clock ticks per second
) (
   // Clock and reset
   input wire MCLK_I,
   input wire SYS_RST_I,
   // Register port
   input wire [3:0] ADDR_I,
   input wire [7:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output reg [7:0] RDATA_O,
   // Host control lines, low is ON
   input wire RTS_N_I,
   input wire DTR_N_I,
   output reg RI_N_O,
   output reg CTS_N_O,
   // Character strobes from and to the serial core
   input wire RX_CHAR_I,
   input wire TX_PEND_I,
   input wire BUSY_I,
   output reg RX_ACCEPT_O,
   output reg TX_GO_O,
   output reg LOW_POWER_O
);
   // Cycle counts derived from times
   // A small TICKS_PER_S shortens every time for simulation
   // Each count is loaded minus one, since zero is a live cycle
   localparam integer ON_CYC = (TICKS_PER_S / 1000) * `RIPS_RI_ON_MS;
   localparam integer OFF_CYC = (TICKS_PER_S / 1000) * `RIPS_RI_OFF_MS;
   localparam integer WAKE_CYC = (TICKS_PER_S / 1000) * `RIPS_WAKE_MS;
   localparam integer SLEEP_CYC = (TICKS_PER_S / 1000) * `RIPS_SLEEP_MS;
   // Ring state codes
   // The pulse state also serves events that land during a call
   localparam [1:0] RG_IDLE = 2'h0;
   localparam [1:0] RG_CALL_ON = 2'h1;
   localparam [1:0] RG_CALL_OFF = 2'h2;
   localparam [1:0] RG_PULSE = 2'h3;

   // Write of a given address
   function wr_hit;
      input [3:0] a;
      input [3:0] want;
      input w;
      begin
         wr_hit = w && (a == want);
      end
   endfunction

   reg [1:0] psc_q; // Power save configuration
   reg hwfc_q; // Hardware flow control enable
   reg sms_en_q; // Message arrival notification enable
   reg evr_en_q; // Event ring enable
   reg [1:0] rts_s_q; // RTS synchroniser
   reg [1:0] dtr_s_q; // DTR synchroniser
   reg rts_on_prev_q; // Previous synced RTS ON
   reg dtr_on_prev_q; // Previous synced DTR ON
   reg [1:0] rg_st_q; // Ring state
   reg [31:0] rg_cnt_q; // Ring timer
   reg uart_en_q; // UART enabled
   reg waking_q; // Wake in progress
   reg [31:0] ps_cnt_q; // Power save timer
   reg call_q; // Call ringing
   reg [1:0] rts_off_chars_q; // Characters sent since RTS off

   // Synchronised line levels, ON is low on the pin
   wire rts_on = ~rts_s_q[1];
   wire dtr_on = ~dtr_s_q[1];
   wire rts_rise = rts_on && !rts_on_prev_q;
   wire dtr_rise = dtr_on && !dtr_on_prev_q;
   wire ev_wr = wr_hit(ADDR_I, `RIPS_ADDR_EVENT, WR_I);
   wire ev_call = ev_wr && WDATA_I[`RIPS_EV_CALL_START];
   wire ev_ans = ev_wr && WDATA_I[`RIPS_EV_CALL_ANSWER];
   wire ev_sms = ev_wr && WDATA_I[`RIPS_EV_SMS] && sms_en_q;
   wire ev_gen = ev_wr && evr_en_q &&
      (WDATA_I[`RIPS_EV_URC] || WDATA_I[`RIPS_EV_DATA]);
   wire ev_pulse = ev_sms || ev_gen;
   // Host wants the UART awake for outgoing data
   wire tx_wake = ev_wr && WDATA_I[`RIPS_EV_WAKE];

   // Two-stage synchronisers for host lines
   // Reset loads the OFF level so no false ON edge follows reset
   // Only the second stage feeds any decision
   // Previous levels give the OFF-to-ON edges for the line modes
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rts_s_q <= 2'h3;
         dtr_s_q <= 2'h3;
         rts_on_prev_q <= 1'b0;
         dtr_on_prev_q <= 1'b0;
      end else begin
         rts_s_q <= {rts_s_q[0], RTS_N_I};
         dtr_s_q <= {dtr_s_q[0], DTR_N_I};
         rts_on_prev_q <= rts_on;
         dtr_on_prev_q <= dtr_on;
      end
   end

   // Mode field of a control write
   wire [1:0] psc_wr = WDATA_I[`RIPS_CTRL_PSC_HI:`RIPS_CTRL_PSC_LO];
   // RTS mode asked for together with flow control
   wire psc_refuse = (psc_wr == `RIPS_PSC_RTS) && WDATA_I[`RIPS_CTRL_HWFC];
   // Mode after the write; a refused request keeps the old mode
   wire [1:0] psc_new = psc_refuse ? psc_q : psc_wr;
   // Flow control may never be on while RTS mode holds
   wire hwfc_new = WDATA_I[`RIPS_CTRL_HWFC] && (psc_new != `RIPS_PSC_RTS);

   // Control register writes
   // New settings take effect on the edge after the write
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         psc_q <= `RIPS_PSC_OFF;
         hwfc_q <= 1'b1;
         sms_en_q <= 1'b0;
         evr_en_q <= 1'b0;
      end else if (wr_hit(ADDR_I, `RIPS_ADDR_CTRL, WR_I)) begin
         // Flow control kept off if RTS mode stays in force
         hwfc_q <= hwfc_new;
         sms_en_q <= WDATA_I[`RIPS_CTRL_SMS_EN]; // Message ring enable
         evr_en_q <= WDATA_I[`RIPS_CTRL_EVR_EN]; // Event ring enable
         // Refused RTS request leaves the mode as it was
         psc_q <= psc_new;
      end
   end

   // Ring indicator sequencer
   // Textual ring notices on the data path play no part here
   // Priority: answer, then event pulse, then call start
   // A pulse during a call resumes the cadence at its off phase
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rg_st_q <= RG_IDLE;
         rg_cnt_q <= 32'h0;
         call_q <= 1'b0;
         RI_N_O <= 1'b1;
      end else begin
         if (ev_ans) begin
            // Answer ends ringing at once
            call_q <= 1'b0;
            rg_st_q <= RG_IDLE;
            rg_cnt_q <= 32'h0;
            RI_N_O <= 1'b1;
         end else if (ev_pulse) begin
            // Retrigger one second hold
            rg_st_q <= RG_PULSE;
            rg_cnt_q <= ON_CYC - 1;
            RI_N_O <= 1'b0;
         end else if (ev_call && !call_q) begin
            call_q <= 1'b1;
            rg_st_q <= RG_CALL_ON;
            rg_cnt_q <= ON_CYC - 1;
            RI_N_O <= 1'b0;
         end else begin
            case (rg_st_q)
               RG_IDLE: begin
                  RI_N_O <= 1'b1;
               end
               RG_CALL_ON: begin
                  // On phase of call cadence
                  if (rg_cnt_q == 32'h0) begin
                     rg_st_q <= RG_CALL_OFF;
                     rg_cnt_q <= OFF_CYC - 1;
                     RI_N_O <= 1'b1;
                  end else begin
                     rg_cnt_q <= rg_cnt_q - 32'h1;
                  end
               end
               RG_CALL_OFF: begin
                  // Off phase of call cadence
                  if (rg_cnt_q == 32'h0) begin
                     rg_st_q <= RG_CALL_ON;
                     rg_cnt_q <= ON_CYC - 1;
                     RI_N_O <= 1'b0;
                  end else begin
                     rg_cnt_q <= rg_cnt_q - 32'h1;
                  end
               end
               RG_PULSE: begin
                  // Event hold, then resume call cadence if ringing
                  if (rg_cnt_q == 32'h0) begin
                     rg_st_q <= call_q ? RG_CALL_OFF : RG_IDLE;
                     rg_cnt_q <= call_q ? OFF_CYC - 1 : 32'h0;
                     RI_N_O <= 1'b1;
                  end else begin
                     rg_cnt_q <= rg_cnt_q - 32'h1;
                  end
               end
               default: begin
                  rg_st_q <= RG_IDLE;
                  RI_N_O <= 1'b1;
               end
            endcase
         end
      end
   end

   // UART enable control per power save mode
   // Mode 0 keeps the UART on for good
   // Mode 1 cycles between a short awake window and a long sleep
   // Modes 2 and 3 follow the chosen host line, with a wake delay
   // Waking counts as disabled: characters are not yet recognised
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         uart_en_q <= 1'b1;
         waking_q <= 1'b0;
         ps_cnt_q <= 32'h0;
      end else begin
         case (psc_q)
            `RIPS_PSC_OFF: begin
               // Always enabled
               uart_en_q <= 1'b1;
               waking_q <= 1'b0;
               ps_cnt_q <= 32'h0;
            end
            `RIPS_PSC_CYCLIC: begin
               if (waking_q) begin
                  // Wake-up delay running
                  if (ps_cnt_q == 32'h0) begin
                     waking_q <= 1'b0;
                     uart_en_q <= 1'b1;
                     ps_cnt_q <= WAKE_CYC - 1;
                  end else begin
                     ps_cnt_q <= ps_cnt_q - 32'h1;
                  end
               end else if (uart_en_q) begin
                  // Awake window, traffic extends it
                  if (RX_CHAR_I || TX_PEND_I || tx_wake) begin
                     ps_cnt_q <= WAKE_CYC - 1;
                  end else if (ps_cnt_q == 32'h0) begin
                     uart_en_q <= 1'b0;
                     ps_cnt_q <= SLEEP_CYC - 1;
                  end else begin
                     ps_cnt_q <= ps_cnt_q - 32'h1;
                  end
               end else if ((RX_CHAR_I && !hwfc_q) || TX_PEND_I || tx_wake) begin
                  // Wake character dropped, wake after delay
                  waking_q <= 1'b1;
                  ps_cnt_q <= WAKE_CYC - 1;
               end else if (ps_cnt_q == 32'h0) begin
                  uart_en_q <= 1'b1;
                  ps_cnt_q <= WAKE_CYC - 1;
               end else begin
                  ps_cnt_q <= ps_cnt_q - 32'h1;
               end
            end
            default: begin
               // RTS or DTR controlled with wake delay
               if ((psc_q == `RIPS_PSC_RTS) ? !rts_on : !dtr_on) begin
                  uart_en_q <= 1'b0;
                  waking_q <= 1'b0;
               end else if ((psc_q == `RIPS_PSC_RTS) ? rts_rise : dtr_rise) begin
                  waking_q <= 1'b1;
                  ps_cnt_q <= WAKE_CYC - 1;
               end else if (waking_q) begin
                  if (ps_cnt_q == 32'h0) begin
                     waking_q <= 1'b0;
                     uart_en_q <= 1'b1;
                  end else begin
                     ps_cnt_q <= ps_cnt_q - 32'h1;
                  end
               end
            end
         endcase
      end
   end

   // Character count after RTS goes off
   // Saturates at two; the host must still take those two
   // Cleared as soon as the synchronised line is back ON
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         rts_off_chars_q <= 2'h0;
      end else if (rts_on) begin
         rts_off_chars_q <= 2'h0;
      end else if (TX_GO_O && rts_off_chars_q != 2'h2) begin
         rts_off_chars_q <= rts_off_chars_q + 2'h1;
      end
   end

   // Gating outputs and read data
   // All outputs leave flip-flops, so each lags its cause by one edge
   // Transmit grants never fall on two edges in a row
   // Read data stand for one cycle, then return to zero
   // Low power is only offered when nothing else keeps the part busy
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         RX_ACCEPT_O <= 1'b0;
         TX_GO_O <= 1'b0;
         CTS_N_O <= 1'b1;
         LOW_POWER_O <= 1'b0;
         RDATA_O <= 8'h00;
      end else begin
         // Receive only when enabled; line modes gate by line level
         RX_ACCEPT_O <= RX_CHAR_I && uart_en_q && !waking_q &&
            !(psc_q == `RIPS_PSC_RTS && !rts_on) &&
            !(psc_q == `RIPS_PSC_DTR && !dtr_on);
         // Flow control holds transmit once two characters have gone with RTS off
         TX_GO_O <= TX_PEND_I && !TX_GO_O &&
            (!hwfc_q || rts_on || rts_off_chars_q != 2'h2);
         CTS_N_O <= !(uart_en_q && !waking_q);
         LOW_POWER_O <= (psc_q != `RIPS_PSC_OFF) && !uart_en_q &&
            !waking_q && !BUSY_I && !TX_PEND_I;
         if (RD_I) begin
            case (ADDR_I)
               `RIPS_ADDR_CTRL: RDATA_O <= {3'h0, evr_en_q, sms_en_q, hwfc_q, psc_q};
               `RIPS_ADDR_STATUS: RDATA_O <= {call_q, RI_N_O, rg_st_q, rts_on,
                  dtr_on, waking_q, uart_en_q};
               default: RDATA_O <= 8'h00;
            endcase
         end else begin
            RDATA_O <= 8'h00;
         end
      end
   end
endmodule // rips_ring_psave
`default_nettype wire

/* File: testbench/rips_props.sv */
`timescale 1ns/1ps
`default_nettype none
module rips_props (
   // Clock and bus
   input wire MCLK_I, input wire SYS_RST_I,
   input wire [3:0] ADDR_I, input wire [7:0] WDATA_I, input wire WR_I,
   // Lines and strobes
   input wire RTS_N_I, input wire DTR_N_I, input wire RI_N_O, input wire CTS_N_O,
   input wire RX_CHAR_I, input wire RX_ACCEPT_O, input wire TX_PEND_I, input wire TX_GO_O
);
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);
   reg [1:0] psc_q; // Shadow mode code
   reg hw_q, sms_q, evr_q; // Shadow enables
   reg [2:0] rts_q; // RTS history
   reg [1:0] go_q; // Grants with RTS settled off
   wire ev = WR_I && ADDR_I == 4'h1; // Event write
   // Shadow of control writes, mode 2 refused under flow control
   always @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         psc_q <= 2'h0;
         {hw_q, sms_q, evr_q} <= 3'h4;
      end else if (WR_I && ADDR_I == 4'h0) begin
         {evr_q, sms_q} <= WDATA_I[4:3];
         hw_q <= WDATA_I[2] && !(WDATA_I[1:0] == 2'h2 && psc_q == 2'h2);
         if (WDATA_I[2:0] != 3'h6) psc_q <= WDATA_I[1:0];
      end
   end
   // Count grants once RTS has stayed off past the synchroniser
   always @(posedge MCLK_I) begin
      rts_q <= SYS_RST_I ? 3'h7 : {rts_q[1:0], RTS_N_I};
      if (SYS_RST_I || !hw_q || !(&rts_q)) go_q <= 2'h0;
      else if (TX_GO_O && go_q != 2'h3) go_q <= go_q + 2'h1;
   end
   sequence s_rts_off; (psc_q == 2'h2 && RTS_N_I) [*5]; endsequence
   sequence s_dtr_off; (psc_q == 2'h3 && DTR_N_I) [*5]; endsequence
   property p_init; $fell(SYS_RST_I) |=> RI_N_O && !CTS_N_O; endproperty
   a_init: assert property (p_init) else $error("bad state after reset");
   property p_call; ev && WDATA_I[0] && !WDATA_I[1] |=> ##[0:1] !RI_N_O; endproperty
   a_call: assert property (p_call) else $error("call not rung");
   property p_sms; ev && WDATA_I[2] && sms_q && !WDATA_I[1] |=> ##[0:1] !RI_N_O; endproperty
   a_sms: assert property (p_sms) else $error("message not rung");
   property p_evr; ev && |WDATA_I[4:3] && evr_q && !WDATA_I[1] |=> ##[0:1] !RI_N_O; endproperty
   a_evr: assert property (p_evr) else $error("event not rung");
   property p_answer; ev && WDATA_I[1] |=> ##[0:1] RI_N_O; endproperty
   a_answer: assert property (p_answer) else $error("ring kept after answer");
   property p_dtr_cts; s_dtr_off |-> CTS_N_O; endproperty
   a_dtr_cts: assert property (p_dtr_cts) else $error("enabled with line off");
   property p_dtr_rx; s_dtr_off ##0 RX_CHAR_I |=> !RX_ACCEPT_O; endproperty
   a_dtr_rx: assert property (p_dtr_rx) else $error("char kept with line off");
   property p_rts_rx; s_rts_off ##0 RX_CHAR_I |=> !RX_ACCEPT_O; endproperty
   a_rts_rx: assert property (p_rts_rx) else $error("char kept with line off");
   property p_tx_hold; go_q != 2'h3; endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("send not halted");
   property p_nofc; !hw_q && TX_PEND_I && !TX_GO_O |=> TX_GO_O; endproperty
   a_nofc: assert property (p_nofc) else $error("send withheld");
endmodule // rips_props
bind rips_ring_psave rips_props chk_u (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
   .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RTS_N_I(RTS_N_I), .DTR_N_I(DTR_N_I),
   .RI_N_O(RI_N_O), .CTS_N_O(CTS_N_O), .RX_CHAR_I(RX_CHAR_I), .RX_ACCEPT_O(RX_ACCEPT_O),
   .TX_PEND_I(TX_PEND_I), .TX_GO_O(TX_GO_O));
`default_nettype wire

/* File: testbench/rips_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rips_host_model (
   // Device side
   input wire logic clk_i, input wire logic cts_n_i, input wire logic tx_go_i,
   // Bench requests
   input wire logic rts_on_i, input wire logic dtr_on_i, input wire logic send_i,
   input wire logic wait_cts_i,
   // Lines toward the device, and count of grants received
   output logic rts_n_o, output logic dtr_n_o, output logic rx_char_o, output int got_o
);
   logic pend_q = 1'b0; // Character waiting to go
   // Lines idle off, as the pull-ups leave them
   initial begin
      rts_n_o = 1'b1;
      dtr_n_o = 1'b1;
      rx_char_o = 1'b0;
      got_o = 0;
   end
   // Control lines, character pulses, received count
   always @(posedge clk_i) begin
      rts_n_o <= !rts_on_i;
      dtr_n_o <= !dtr_on_i;
      rx_char_o <= 1'b0;
      if (send_i) pend_q <= 1'b1;
      else if (pend_q && (!wait_cts_i || !cts_n_i)) begin
         pend_q <= 1'b0;
         rx_char_o <= 1'b1;
      end
      if (tx_go_i) got_o <= got_o + 1;
   end
endmodule // rips_host_model
`default_nettype wire

/* File: testbench/rips_ring_psave_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
module rips_ring_psave_tb;
   logic clk = 1'b0, rst = 1'b1; // Clock, reset
   logic [3:0] addr = 4'h0; // Bus address
   logic [7:0] wdata = 8'h00, v; // Bus data
   logic wr_s = 1'b0, rd_s = 1'b0, tx_pend = 1'b0; // Strobes
   logic rts_on = 1'b0, dtr_on = 1'b0, send = 1'b0, wait_cts = 1'b0; // Host controls
   wire [7:0] rdata; // Read data
   wire rts_n, dtr_n, rx_char, ri_n, cts_n, rx_acc, tx_go, lp; // Lines
   int got, acc = 0, num_checks = 0, err_total = 0, n, a; // Counters
   always #25 clk = ~clk;
   // Count accepted characters
   always @(posedge clk) if (rx_acc) acc <= acc + 1;
   rips_ring_psave #(.TICKS_PER_S(1000)) dut_u (.MCLK_I(clk), .SYS_RST_I(rst), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata), .RTS_N_I(rts_n),
      .DTR_N_I(dtr_n), .RI_N_O(ri_n), .CTS_N_O(cts_n), .RX_CHAR_I(rx_char),
      .TX_PEND_I(tx_pend), .BUSY_I(1'b0), .RX_ACCEPT_O(rx_acc), .TX_GO_O(tx_go),
      .LOW_POWER_O(lp));
   rips_host_model host_u (.clk_i(clk), .cts_n_i(cts_n), .tx_go_i(tx_go), .rts_on_i(rts_on),
      .dtr_on_i(dtr_on), .send_i(send), .wait_cts_i(wait_cts), .rts_n_o(rts_n),
      .dtr_n_o(dtr_n), .rx_char_o(rx_char), .got_o(got));
   task conclude;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task wr(input logic [3:0] ad, input logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task rd(input logic [3:0] ad, output logic [7:0] d);
      @(posedge clk);
      addr <= ad;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
   // Wait for ring level, then count cycles it lasts
   task span(input logic lvl);
      n = 0;
      while (ri_n !== lvl && n < 9000) begin @(negedge clk); n++; end
      if (n < 9000) n = 0;
      while (ri_n === lvl && n < 9000) begin @(negedge clk); n++; end
      if (n >= 9000) begin err_total++; conclude; end
   endtask
   task chr;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (5) @(posedge clk);
   endtask
   // Line off drops characters, line on wakes and accepts
   task gate(input logic [7:0] c, input logic dl);
      wr(4'h0, c);
      rts_on <= 1'b0;
      dtr_on <= 1'b0;
      repeat (10) @(posedge clk);
      a = acc;
      chr;
      `CHK(cts_n, 1'b1, "cts not off")
      `CHK(acc - a, 0, "char kept")
      if (dl) dtr_on <= 1'b1;
      else rts_on <= 1'b1;
      repeat (40) @(posedge clk);
      a = acc;
      chr;
      `CHK(cts_n, 1'b0, "cts not on")
      `CHK(acc - a, 1, "char lost")
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(4'h0, v);
      `CHK(v, 8'h04, "ctrl reset")
      `CHK(ri_n, 1'b1, "ring idle")
      `CHK(cts_n, 1'b0, "cts at reset")
      rd(4'h9, v);
      `CHK(v, 8'h00, "unmapped read")
      rd(4'h2, v);
      `CHK(v, 8'h41, "status reset")
      for (int p = 0; p < 4; p++) begin
         wr(4'h0, 8'(p));
         rd(4'h0, v);
         `CHK(v, 8'(p), "mode code")
      end
      wr(4'h0, 8'h06);
      rd(4'h0, v);
      `CHK(v, 8'h07, "mode 2 refused")
      gate(8'h02, 1'b0);
      wr(4'h0, 8'h06);
      rd(4'h0, v);
      `CHK(v, 8'h02, "flow control kept off")
      gate(8'h07, 1'b1);
      wr(4'h0, 8'h0C);
      wr(4'h1, 8'h04);
      span(1'b0);
      `CHK(n, 1000, "message pulse")
      wr(4'h1, 8'h04);
      repeat (500) @(posedge clk);
      wr(4'h1, 8'h04);
      span(1'b0);
      `CHK(n > 990 && n < 1005, 1'b1, "retrigger")
      wr(4'h0, 8'h04);
      wr(4'h1, 8'h04);
      repeat (3) @(negedge clk);
      `CHK(ri_n, 1'b1, "message masked")
      wr(4'h0, 8'h14);
      for (int b = 3; b < 5; b++) begin
         wr(4'h1, 8'h01 << b);
         span(1'b0);
         `CHK(n, 1000, "event pulse")
      end
      wr(4'h1, 8'h01);
      span(1'b0);
      `CHK(n, 1000, "ring on")
      span(1'b1);
      `CHK(n, 4000, "ring off")
      repeat (100) @(posedge clk);
      wr(4'h1, 8'h02);
      repeat (2) @(negedge clk);
      `CHK(ri_n, 1'b1, "answered")
      repeat (6000) @(posedge clk);
      `CHK(ri_n, 1'b1, "call over")
      // Cyclic mode, no flow control: sleep, wake by a dropped character
      wr(4'h0, 8'h01);
      repeat (5) @(posedge clk);
      `CHK(cts_n, 1'b1, "cyclic asleep")
      `CHK(lp, 1'b1, "low power offered")
      a = acc;
      chr;
      `CHK(acc - a, 0, "wake char kept")
      repeat (30) @(posedge clk);
      `CHK(cts_n, 1'b0, "not woken")
      `CHK(lp, 1'b0, "low power while awake")
      a = acc;
      chr;
      `CHK(acc - a, 1, "awake char lost")
      repeat (40) @(posedge clk);
      `CHK(cts_n, 1'b1, "awake too long")
      n = 0;
      while (cts_n !== 1'b0 && n < 3000) begin @(negedge clk); n++; end
      if (n >= 3000) begin err_total++; conclude; end
      `CHK(n > 2400 && n < 2500, 1'b1, "sleep length")
      // Cyclic mode with flow control: host holds until CTS is on
      wr(4'h0, 8'h05);
      repeat (40) @(posedge clk);
      a = acc;
      wait_cts <= 1'b1;
      chr;
      `CHK(acc - a, 0, "host sent early")
      repeat (2600) @(posedge clk);
      `CHK(acc - a, 1, "held char lost")
      wait_cts <= 1'b0;
      wr(4'h0, 8'h04);
      rts_on <= 1'b0;
      repeat (10) @(posedge clk);
      a = got;
      tx_pend <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK(got - a <= 2, 1'b1, "send held")
      rts_on <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK(got - a > 20, 1'b1, "send resumed")
      rts_on <= 1'b0;
      wr(4'h0, 8'h00);
      a = got;
      repeat (60) @(posedge clk);
      `CHK(got - a > 20, 1'b1, "send free")
      conclude;
   end
endmodule // rips_ring_psave_tb
`default_nettype wire
